// ==== include/asr_pkg.sv ====
package asr_pkg;

    // =====================================================================
    // memory geometry
    // =====================================================================
    localparam int ASR_ADDR_W = 17;
    localparam int ASR_DATA_W = 8;

    // =====================================================================
    // timing (slowest grade, ns) and cycle counts at 40 MHz
    // =====================================================================
    localparam int ASR_CLK_PERIOD_NS = 25;
    localparam int ASR_T_ACCESS_NS   = 35;
    localparam int ASR_T_WPULSE_NS   = 25;
    localparam int ASR_T_TURN_NS     = 15;
    localparam int ASR_ACCESS_CYC    =
        (ASR_T_ACCESS_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
    localparam int ASR_WPULSE_CYC    =
        (ASR_T_WPULSE_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
    localparam int ASR_TURN_CYC      = (ASR_T_TURN_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
    localparam int ASR_CNT_W         = 4;

    // =====================================================================
    // pin and request carriers
    // =====================================================================
    typedef struct packed {
        logic                  chip_select_n;
        logic                  chip_select_hi;
        logic                  output_enable_n;
        logic                  write_enable_n;
        logic [ASR_ADDR_W-1:0] addr_lines;
    } asr_pins_s;

    typedef struct packed {
        logic                  write;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_s;

    localparam asr_pins_s ASR_PINS_IDLE = '{
        chip_select_n:   1'b1,
        chip_select_hi:  1'b0,
        output_enable_n: 1'b1,
        write_enable_n:  1'b1,
        addr_lines:      17'h0_0000
    };

    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_RD_SETUP,
        ASR_RD_WAIT,
        ASR_WR_SETUP,
        ASR_WR_PULSE,
        ASR_WR_END,
        ASR_TURN
    } asr_state_e;

endpackage

// ==== logic/asr_host.sv ====
`timescale 1ns/100ps
module asr_host
    import asr_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  req_valid_i,
    input  wire asr_req_s              req_i,
    output logic                       req_ready_o,
    output logic                       rd_valid_o,
    output logic [ASR_DATA_W-1:0]      rd_data_o,
    output asr_pins_s                  pins_o,
    input  wire logic [ASR_DATA_W-1:0] data_lines_i,
    output logic [ASR_DATA_W-1:0]      data_lines_o,
    output logic                       data_lines_oe_o
);

    // =====================================================================
    // state
    // =====================================================================
    asr_state_e            state_r;
    asr_state_e            state_nxt;
    logic [ASR_CNT_W-1:0]  cnt_r;
    logic [ASR_CNT_W-1:0]  cnt_nxt;
    asr_pins_s             pins_r;
    logic [ASR_DATA_W-1:0] wdata_r;
    logic                  drive_r;
    logic                  rd_valid_r;
    logic [ASR_DATA_W-1:0] rd_data_r;

    // a zero count would wrap the counter into a long wait, so refuse it too
    if (ASR_ACCESS_CYC >= (1 << ASR_CNT_W) || ASR_WPULSE_CYC >= (1 << ASR_CNT_W)
        || ASR_TURN_CYC >= (1 << ASR_CNT_W) || ASR_ACCESS_CYC < 1
        || ASR_WPULSE_CYC < 1 || ASR_TURN_CYC < 1)
    begin : g_cnt_check
        $error("asr_host: cycle counts do not fit the counter");
    end

    function automatic logic [ASR_CNT_W-1:0] cnt_of(input int cycles);
        cnt_of = ASR_CNT_W'(cycles - 1);
    endfunction

    // =====================================================================
    // sequencing
    // =====================================================================
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        case (state_r)
            ASR_IDLE:
            begin
                if (req_valid_i)
                begin
                    state_nxt = req_i.write ? ASR_WR_SETUP : ASR_RD_SETUP;
                end
            end
            ASR_RD_SETUP:
            begin
                state_nxt = ASR_RD_WAIT;
                cnt_nxt   = cnt_of(ASR_ACCESS_CYC);
            end
            ASR_RD_WAIT:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = ASR_TURN;
                    cnt_nxt   = cnt_of(ASR_TURN_CYC);
                end
            end
            ASR_WR_SETUP:
            begin
                state_nxt = ASR_WR_PULSE;
                cnt_nxt   = cnt_of(ASR_WPULSE_CYC);
            end
            ASR_WR_PULSE:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = ASR_WR_END;
                end
            end
            ASR_WR_END:
            begin
                state_nxt = ASR_IDLE;
            end
            ASR_TURN:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = ASR_IDLE;
                end
            end
            default:
            begin
                state_nxt = ASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ASR_IDLE;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // =====================================================================
    // memory pins
    // =====================================================================
    // address is latched in idle and only moves there, so it is valid a
    // full cycle before any select and stays put until selects drop
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            pins_r <= ASR_PINS_IDLE;
        end
        else
        begin
            case (state_nxt)
                ASR_IDLE, ASR_TURN:
                begin
                    pins_r.chip_select_n   <= 1'b1;
                    pins_r.chip_select_hi  <= 1'b0;
                    pins_r.output_enable_n <= 1'b1;
                    pins_r.write_enable_n  <= 1'b1;
                    if (state_r == ASR_IDLE && req_valid_i)
                    begin
                        pins_r.addr_lines <= req_i.addr;
                    end
                end
                ASR_RD_SETUP, ASR_WR_SETUP:
                begin
                    pins_r.addr_lines <= req_i.addr;
                end
                ASR_RD_WAIT:
                begin
                    pins_r.chip_select_n   <= 1'b0;
                    pins_r.chip_select_hi  <= 1'b1;
                    pins_r.output_enable_n <= 1'b0;
                    pins_r.write_enable_n  <= 1'b1;
                end
                ASR_WR_PULSE:
                begin
                    pins_r.chip_select_n   <= 1'b0;
                    pins_r.chip_select_hi  <= 1'b1;
                    pins_r.output_enable_n <= 1'b1;
                    pins_r.write_enable_n  <= 1'b0;
                end
                ASR_WR_END:
                begin
                    // write ends on we_n alone; selects drop a cycle later
                    pins_r.write_enable_n  <= 1'b1;
                end
                default:
                begin
                    pins_r <= ASR_PINS_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // data bus
    // =====================================================================
    // drivers come on with setup (oe_n is high, device floats) and stay on
    // through the write-ending cycle so data holds past the we_n edge
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            drive_r <= 1'b0;
            wdata_r <= '0;
        end
        else
        begin
            drive_r <= (state_nxt == ASR_WR_SETUP) || (state_nxt == ASR_WR_PULSE)
                       || (state_nxt == ASR_WR_END);
            if (state_r == ASR_IDLE && req_valid_i && req_i.write)
            begin
                wdata_r <= req_i.wdata;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= '0;
        end
        else
        begin
            rd_valid_r <= (state_r == ASR_RD_WAIT) && (cnt_r == '0);
            if ((state_r == ASR_RD_WAIT) && (cnt_r == '0))
            begin
                rd_data_r <= data_lines_i;
            end
        end
    end

    assign req_ready_o     = (state_r == ASR_IDLE);
    assign rd_valid_o      = rd_valid_r;
    assign rd_data_o       = rd_data_r;
    assign pins_o          = pins_r;
    assign data_lines_o    = wdata_r;
    assign data_lines_oe_o = drive_r;

endmodule

// ==== bench/asr_sram_model.sv ====
`timescale 1ns/100ps
module asr_sram_model
    import asr_pkg::*;
#(
    parameter int ACC_NS = 35
)
(
    input  wire asr_pins_s             pins_i,
    input  wire logic [ASR_DATA_W-1:0] data_i,
    output logic [ASR_DATA_W-1:0]      data_o,
    output logic                       drive_o
);
    logic [ASR_DATA_W-1:0] mem_r [0:(1<<ASR_ADDR_W)-1];
    logic [ASR_DATA_W-1:0] last_r = 8'h00;
    logic [ASR_DATA_W-1:0] out_r;
    wire sel = !pins_i.chip_select_n && pins_i.chip_select_hi;
    wire wr = sel && !pins_i.write_enable_n;
    assign drive_o = sel && !pins_i.output_enable_n && pins_i.write_enable_n;
    // stored when the overlap ends, whichever pin ends it
    always @(negedge wr) mem_r[pins_i.addr_lines] = data_i;
    always @* if (drive_o) last_r = mem_r[pins_i.addr_lines];
    // released lines show the inverse so a stale byte never passes
    always @* out_r = drive_o ? last_r : ~last_r;
    assign #(ACC_NS) data_o = out_r;
endmodule

// ==== bench/asr_host_sva.sv ====
`timescale 1ns/100ps
module asr_host_sva
    import asr_pkg::*;
(
    input wire logic                  clock_i,
    input wire logic                  rst_n_i,
    input wire logic                  req_valid_i,
    input wire asr_req_s              req_i,
    input wire logic                  req_ready_o,
    input wire logic                  rd_valid_o,
    input wire logic [ASR_DATA_W-1:0] rd_data_o,
    input wire asr_pins_s             pins_o,
    input wire logic [ASR_DATA_W-1:0] data_lines_i,
    input wire logic [ASR_DATA_W-1:0] data_lines_o,
    input wire logic                  data_lines_oe_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    wire sel = !pins_o.chip_select_n && pins_o.chip_select_hi;
    wire wr = sel && !pins_o.write_enable_n;
    sequence take_rd;
        req_valid_i && req_ready_o && !req_i.write;
    endsequence
    sequence take_wr;
        req_valid_i && req_ready_o && req_i.write;
    endsequence
    sequence rd_on;
        sel && !pins_o.output_enable_n && pins_o.write_enable_n;
    endsequence
    a_read_no_write: assert property (sel && !pins_o.output_enable_n |-> pins_o.write_enable_n)
        else $error("write enable low in read");
    a_no_contention: assert property (!pins_o.output_enable_n |-> !data_lines_oe_o)
        else $error("host drives while output enabled");
    a_addr_hold: assert property ($past(wr) |-> $stable(pins_o.addr_lines))
        else $error("address moved in write");
    a_data_hold: assert property ($past(wr) |-> data_lines_oe_o && $stable(data_lines_o))
        else $error("write data not held");
    a_rd_latency: assert property (take_rd |=> !rd_valid_o [*3] ##1 rd_valid_o)
        else $error("read answer late or early");
    a_rd_addr_first: assert property (take_rd |=> !sel && pins_o.addr_lines == $past(req_i.addr)
        ##1 rd_on [*2] ##1 !sel) else $error("read select order wrong");
    a_wr_walk: assert property (take_wr |=> !sel && data_lines_oe_o
        && data_lines_o == $past(req_i.wdata) && pins_o.addr_lines == $past(req_i.addr)
        ##1 wr ##1 sel && pins_o.write_enable_n) else $error("write walk wrong");
    a_idle_quiet: assert property (req_ready_o |-> !sel && !data_lines_oe_o)
        else $error("idle with pins active");
endmodule
bind asr_host asr_host_sva chk_u (.clock_i, .rst_n_i, .req_valid_i, .req_i, .req_ready_o,
    .rd_valid_o, .rd_data_o, .pins_o, .data_lines_i, .data_lines_o, .data_lines_oe_o);

// ==== bench/test_async_sram_128k_by_8.sv ====
`timescale 1ns/100ps
module test_async_sram_128k_by_8
    import asr_pkg::*;
;
    logic                  clock_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  req_valid_i = 1'b0;
    asr_req_s              req_i = '0;
    logic                  req_ready_o, rd_valid_o, mdl_drive, host_oe;
    logic [ASR_DATA_W-1:0] rd_data_o, host_d, mdl_d, wire_d;
    asr_pins_s             pins_o;
    int                    miscompares = 0;
    int                    n_checks = 0;
    always #12.5 clock_i = ~clock_i;
    // both sides driving at once shows as unknown so contention cannot hide
    assign wire_d = (host_oe && mdl_drive) ? 'x : (host_oe ? host_d : mdl_d);
    asr_host dut_u (.clock_i, .rst_n_i, .req_valid_i, .req_i, .req_ready_o, .rd_valid_o,
        .rd_data_o, .pins_o, .data_lines_i(wire_d), .data_lines_o(host_d),
        .data_lines_oe_o(host_oe));
    asr_sram_model mdl_u (.pins_i(pins_o), .data_i(wire_d), .data_o(mdl_d), .drive_o(mdl_drive));
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_byte(input logic [ASR_DATA_W-1:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    // one request; a read waits for its answer and compares it with d
    task automatic xfer(input logic wr, input logic [ASR_ADDR_W-1:0] a,
                        input logic [ASR_DATA_W-1:0] d);
        int k;
        k = 0;
        @(negedge clock_i);
        req_valid_i = 1'b1;
        req_i = '{write: wr, addr: a, wdata: d};
        while (req_ready_o !== 1'b1 && k < 20)
        begin
            k++;
            @(negedge clock_i);
        end
        chk_bit(req_ready_o, 1'b1);
        @(negedge clock_i);
        req_valid_i = 1'b0;
        while (!wr && rd_valid_o !== 1'b1 && k < 30)
        begin
            k++;
            @(negedge clock_i);
        end
        if (!wr)
        begin
            chk_bit(rd_valid_o, 1'b1);
            chk_byte(rd_data_o, d);
        end
    endtask
    task automatic test_bounds();
        logic [ASR_ADDR_W-1:0] a [3] = '{17'h0_0000, 17'h1_ffff, 17'h0_5555};
        logic [ASR_DATA_W-1:0] d [3] = '{8'ha5, 8'h5a, 8'hff};
        foreach (a[i]) xfer(1'b1, a[i], d[i]);
        foreach (a[i]) xfer(1'b0, a[i], d[i]);
        $display("test bounds done");
    endtask
    task automatic test_overwrite();
        xfer(1'b1, 17'h1_0001, 8'h3c);
        xfer(1'b0, 17'h1_0001, 8'h3c);
        xfer(1'b1, 17'h1_0001, 8'hc3);
        xfer(1'b0, 17'h1_0001, 8'hc3);
        $display("test overwrite done");
    endtask
    // reset lands mid-read; pins must fall back to idle and memory keep its bytes
    task automatic test_reset();
        @(negedge clock_i);
        req_valid_i = 1'b1;
        req_i = '{write: 1'b0, addr: 17'h0_5555, wdata: 8'h00};
        @(negedge clock_i);
        req_valid_i = 1'b0;
        @(negedge clock_i);
        rst_n_i = 1'b0;
        @(negedge clock_i);
        chk_bit(pins_o === ASR_PINS_IDLE, 1'b1);
        chk_bit(host_oe, 1'b0);
        chk_bit(rd_valid_o, 1'b0);
        chk_bit(mdl_drive, 1'b0);
        rst_n_i = 1'b1;
        xfer(1'b0, 17'h0_5555, 8'hff);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (2000) @(posedge clock_i);
        miscompares++;
        give_verdict();
    end
    initial
    begin
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
        test_bounds();
        test_overwrite();
        test_reset();
        give_verdict();
    end
endmodule
